/* File: bench/sees_bus_master.sv */
/*
  Behavioural two-wire bus master that drives the EEPROM slave.
  Assumes the bench resolves a pulled-up data wire; the clock idles high.
*/
module sees_bus_master (
  input  wire logic       clk_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            sda_low_out,
  output logic            res_stb_out,
  output logic [7:0]      res_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QTR = 10;

  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
    res_stb_out = 1'b0;
    res_out     = 8'h00;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wt

  task automatic post(input logic [7:0] v);
    res_out     <= v;
    res_stb_out <= 1'b1;
    wt(1);
    res_stb_out <= 1'b0;
  endtask : post

  // data moves mid-low and is sampled mid-high, so no false condition
  task automatic bit_x(input logic b, output logic r);
    wt(QTR);
    sda_low_out <= ~b;
    wt(QTR);
    scl_out <= 1'b1;
    wt(QTR);
    r = sda_in;
    wt(QTR);
    scl_out <= 1'b0;
  endtask : bit_x

  // also serves as a repeated start from a low clock
  task automatic start();
    wt(QTR);
    sda_low_out <= 1'b0;
    wt(QTR);
    scl_out <= 1'b1;
    wt(QTR);
    sda_low_out <= 1'b1;
    wt(QTR);
    scl_out <= 1'b0;
  endtask : start

  task automatic stop();
    wt(QTR);
    sda_low_out <= 1'b1;
    wt(QTR);
    scl_out <= 1'b1;
    wt(QTR);
    sda_low_out <= 1'b0;
    wt(QTR);
  endtask : stop

  task automatic wr_byte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    post({7'h00, ~r});
  endtask : wr_byte

  task automatic rd_byte(input logic mack);
    logic [7:0] d;
    logic       r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~mack, r);
    post(d);
  endtask : rd_byte
endmodule : sees_bus_master

/* File: bench/sees_eeprom_slave_tb.sv */
/*
  Self-checking bench: byte and page writes, reads, cache wrap, refusals.
  Assumes the package, the slave and the bus master are compiled first.
*/
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    num_errors++; \
    $display("ERROR %0t got %h want %h", $time, a, e); \
  end \
end

module sees_eeprom_slave_tb
  import sees_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] TC = 4'h6; // arbitrary type code
  localparam int WPG = 400;
  localparam int LIMIT = 80000;
  logic clk_in, arst_n, scl, m_low, oe, sda_o, busy, stb;
  logic [7:0] res, exp_v;
  logic [2:0] cs;
  wire sda = ~(m_low | oe);
  int num_errors = 0, n_tests = 0, cyc = 0, blen = 0;
  logic [7:0] q[$];
  logic [7:0] img [logic [12:0]];

  sees_eeprom_slave #(.TYPE_CODE(TC), .PAGE_WR_CYCLES(WPG)) dut (
    .clk_in(clk_in), .arst_n_in(arst_n), .scl_in(scl), .sda_in(sda),
    .chip_select_bit_low_in(cs[0]), .chip_select_bit_mid_in(cs[1]),
    .chip_select_bit_high_in(cs[2]), .sda_out(sda_o), .sda_oe_out(oe),
    .busy_out(busy));
  sees_bus_master u_m (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(m_low), .res_stb_out(stb), .res_out(res));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) blen <= blen + 1;
    if (stb === 1'b1) begin
      exp_v = q.pop_front();
      `CHK(res, exp_v)
    end
    if (cyc == LIMIT) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic send(input logic [7:0] d, input logic a);
    q.push_back({7'h00, a});
    u_m.wr_byte(d);
  endtask : send

  task automatic go(input logic rd, input logic a);
    u_m.start();
    send({TC, cs, rd}, a);
  endtask : go

  task automatic set_ptr(input logic [12:0] a);
    go(1'b0, 1'b1);
    send({3'h0, a[12:8]}, 1'b1);
    send(a[7:0], 1'b1);
  endtask : set_ptr

  task automatic recv(input logic [12:0] a, input logic mack);
    q.push_back(img[a]);
    u_m.rd_byte(mack);
  endtask : recv

  // bytes land at the row base plus a cache slot that wraps at 64
  task automatic pw(input logic [12:0] a, input int n);
    logic [7:0] d;
    set_ptr(a);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      img[{a[12:3], 3'h0} + 13'((a[2:0] + i) % CACHE_BYTES)] = d;
      send(d, 1'b1);
    end
  endtask : pw

  // a write poll during programming must go unanswered
  task automatic commit(input int pages);
    blen = 0;
    u_m.stop();
    `CHK(busy, 1'b1)
    go(1'b0, 1'b0);
    u_m.stop();
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk_in);
    `CHK(blen >= 64 + pages * WPG && blen <= 66 + pages * WPG, 1'b1)
  endtask : commit

  initial begin
    logic [7:0] d;
    cs     = 3'h0;
    arst_n = 1'b0;
    d      = 8'($urandom(32'hf43f2e9a));
    repeat (8) @(posedge clk_in);
    cs     <= 3'($urandom);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk_in);
    d = 8'($urandom);
    img[13'h0123] = d;
    set_ptr(13'h0123);
    send(d, 1'b1);
    commit(1);
    $display("test byte_write finished");
    pw(13'h0306, 12);
    commit(3);
    $display("test page_write finished");
    set_ptr(13'h0123);
    go(1'b1, 1'b1);
    recv(13'h0123, 1'b0);
    u_m.stop();
    set_ptr(13'h0306);
    go(1'b1, 1'b1);
    recv(13'h0306, 1'b0);
    u_m.stop();
    go(1'b1, 1'b1);
    recv(13'h0307, 1'b0);
    u_m.stop();
    go(1'b1, 1'b1);
    for (int i = 8; i < 18; i++) recv(13'h0300 + 13'(i), i < 17);
    u_m.stop();
    $display("test reads finished");
    pw(13'h0400, CACHE_BYTES + 2);
    commit(CACHE_PAGES);
    set_ptr(13'h0400);
    go(1'b1, 1'b1);
    for (int i = 0; i < PAGE_BYTES; i++)
      recv(13'h0400 + 13'(i), i < PAGE_BYTES - 1);
    u_m.stop();
    $display("test cache_wrap finished");
    for (int k = 0; k < 4; k++) begin
      u_m.start();
      send({TC ^ {3'h0, k == 3}, cs ^ 3'(1 << k), 1'b1}, 1'b0);
      u_m.stop();
    end
    set_ptr(13'h0306);
    send(~img[13'h0306], 1'b1);
    go(1'b1, 1'b1);
    recv(13'h0307, 1'b0);
    u_m.stop();
    `CHK(busy, 1'b0)
    // the abandoned byte must not have reached the array
    set_ptr(13'h0306);
    go(1'b1, 1'b1);
    recv(13'h0306, 1'b0);
    u_m.stop();
    `CHK(sda_o, 1'b0)
    `CHK(q.size(), 0)
    $display("test refuse_abort finished");
    report_and_stop();
  end
endmodule : sees_eeprom_slave_tb

/* File: common/sees_pkg.sv */
/*
  Shared constants and types of the serial EEPROM bus slave.
  Assumes a single 250 MHz core clock; bus lines are sampled, not clocks.
*/
package sees_pkg;
  localparam int ADDR_W      = 13;
  localparam int MEM_WORDS   = 8192;
  localparam int CACHE_BYTES = 64;
  localparam int PAGE_BYTES  = 8;
  localparam int CACHE_PAGES = 8;
  localparam int SLOT_W      = 6;

  // type code of the control byte; value is arbitrary
  localparam logic [3:0] TYPE_CODE_DEF = 4'h5;

  localparam logic       RW_READ  = 1'b1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_DONE = 4'h8;
  localparam logic [3:0] BIT_RST  = 4'h0;

  localparam logic [ADDR_W-1:0] PTR_RST   = 13'h0000;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 6'h3f;

  // one page program time and the cycle count derived from it
  localparam int TWR_MS      = 5;
  localparam int CLK_KHZ     = 250000;
  localparam int TWR_CYC_DEF = TWR_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_RX,
    BUS_RX_ACK,
    BUS_TX,
    BUS_TX_ACK,
    BUS_WAIT
  } sees_bus_e;

  typedef enum logic [1:0] {
    ROLE_CTRL,
    ROLE_ADDR_HI,
    ROLE_ADDR_LO,
    ROLE_DATA
  } sees_role_e;

  typedef enum logic [1:0] {
    CM_IDLE,
    CM_COPY,
    CM_WAIT
  } sees_commit_e;
endpackage : sees_pkg

/* File: rtl/sees_eeprom_slave.sv */
/*
  Two-wire serial EEPROM slave: bus protocol engine, 64-byte page cache,
  storage array and the timed commit of the cache after STOP.
  Assumes an external open-drain wire: sda_oe_out high pulls the line low.
*/
// Summary of operation
// - both lines high means idle; transfers start only from idle.
// - data falling while clock high is START; device detects it.
// - data rising while clock high is STOP; device detects it.
// - data changes only while clock low; one clock pulse per bit.
// - receiver acknowledges every byte on a ninth master clock pulse.
// - acknowledger holds data low through the acknowledge clock high.
// - no acknowledge at all while the internal program cycle runs.
// - master withholds ack on last read byte; device releases data.
// - control byte is type code, three select bits, direction bit.
// - direction bit one reads, zero writes.
// - acknowledge control byte only on type and select match.
// - write sends two address bytes, high first; top three bits zero.
// - page write loads up to 64 bytes, committed only after STOP.
// - each data byte increments low six pointer bits, upper seven kept.
// - past a full cache the slot wraps to zero and overwrites.
// - STOP may follow any byte; STOP starts the program cycle.
// - current read returns byte at last address plus one.
// - repeated START after address aborts write but keeps pointer.
// - master ack on read byte sends next byte; pointer advances.
// - program time is one page time per loaded cache page.
// - every bus command is ignored while programming.
module sees_eeprom_slave
  import sees_pkg::*;
#(
  parameter logic [3:0] TYPE_CODE      = TYPE_CODE_DEF,
  parameter int         PAGE_WR_CYCLES = TWR_CYC_DEF
) (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic chip_select_bit_low_in,
  input  wire logic chip_select_bit_mid_in,
  input  wire logic chip_select_bit_high_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  output logic      busy_out
);
  if (PAGE_WR_CYCLES < 1 || PAGE_WR_CYCLES > 268435455) begin : g_chk
    $error("PAGE_WR_CYCLES out of range");
  end

  function automatic logic [3:0] pages_loaded(input logic [63:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int p = 0; p < CACHE_PAGES; p++) begin
      n = n + {3'h0, |v[p*PAGE_BYTES +: PAGE_BYTES]};
    end
    return n;
  endfunction : pages_loaded

  logic              sda_s;
  logic [2:0]        cs_s;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_c;
  logic              stop_c;

  sees_bus_e         bus_ff;
  sees_role_e        role_ff;
  sees_commit_e      cm_ff;
  logic [3:0]        bitcnt_ff;
  logic [7:0]        shift_ff;
  logic [7:0]        tx_sh_ff;
  logic              drive_ff;
  logic              ack_ff;
  logic              loaded_ff;
  logic [4:0]        ahi_ff;
  logic [ADDR_W-1:0] ptr_ff;
  logic [ADDR_W-1:0] base_ff;
  logic [SLOT_W-1:0] slot_ff;
  logic [SLOT_W-1:0] cslot_ff;
  logic [63:0]       valid_ff;
  logic [31:0]       wait_ff;
  logic [7:0]        cache_ff [0:CACHE_BYTES-1];
  logic [7:0]        mem_ff   [0:MEM_WORDS-1];

  logic [7:0]        rx_byte;
  logic [7:0]        rd_byte;
  logic              byte_done;
  logic              ctrl_match;
  logic              ack_ok;
  logic              busy;
  logic              data_stb;
  logic              alo_stb;
  logic              ahi_stb;
  logic              tx_adv;
  logic              commit_go;

  sees_line_sync u_sync (
    .clk_in       (clk_in),
    .arst_n_in    (arst_n_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .cs_in        ({chip_select_bit_high_in, chip_select_bit_mid_in,
                    chip_select_bit_low_in}),
    .sda_s_out    (sda_s),
    .cs_s_out     (cs_s),
    .scl_rise_out (scl_rise),
    .scl_fall_out (scl_fall),
    .start_out    (start_c),
    .stop_out     (stop_c)
  );

  assign busy      = (cm_ff != CM_IDLE);
  assign rx_byte   = {shift_ff[6:0], sda_s};
  assign rd_byte   = mem_ff[ptr_ff];
  assign byte_done = (bus_ff == BUS_RX) && scl_rise && (bitcnt_ff == BIT_LAST);
  // select bits are compared against the pins and do not enter the address
  assign ctrl_match = (rx_byte[7:4] == TYPE_CODE)
                   && (rx_byte[3:1] == cs_s);
  assign ack_ok = (role_ff == ROLE_CTRL) ? (ctrl_match && !busy)
                                         : !busy;
  assign ahi_stb  = byte_done && (role_ff == ROLE_ADDR_HI);
  assign alo_stb  = byte_done && (role_ff == ROLE_ADDR_LO);
  assign data_stb = byte_done && (role_ff == ROLE_DATA);
  assign tx_adv   = (bus_ff == BUS_TX) && scl_rise && (bitcnt_ff == BIT_LAST);
  assign commit_go = stop_c && loaded_ff && !busy;

  assign sda_out    = 1'b0;
  assign sda_oe_out = drive_ff;
  assign busy_out   = busy;

  // bus protocol engine; a START while programming only returns it to idle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_ff    <= BUS_IDLE;
      role_ff   <= ROLE_CTRL;
      bitcnt_ff <= BIT_RST;
      shift_ff  <= 8'h00;
      tx_sh_ff  <= 8'hff;
      drive_ff  <= 1'b0;
      ack_ff    <= 1'b0;
    end else if (start_c && !busy) begin
      bus_ff    <= BUS_RX;
      role_ff   <= ROLE_CTRL;
      bitcnt_ff <= BIT_RST;
      drive_ff  <= 1'b0;
    end else if (stop_c || start_c) begin
      bus_ff   <= BUS_IDLE;
      drive_ff <= 1'b0;
    end else begin
      unique case (bus_ff)
        BUS_IDLE, BUS_WAIT: begin
          drive_ff <= 1'b0;
        end
        BUS_RX: begin
          if (scl_rise) begin
            shift_ff  <= rx_byte;
            bitcnt_ff <= bitcnt_ff + 4'h1;
            if (bitcnt_ff == BIT_LAST) begin
              ack_ff <= ack_ok;
            end
          end else if (scl_fall && bitcnt_ff == BIT_DONE) begin
            // silence on a mismatch or while busy leaves the line high
            if (ack_ff) begin
              drive_ff <= 1'b1;
              bus_ff   <= BUS_RX_ACK;
            end else begin
              bus_ff <= BUS_WAIT;
            end
          end
        end
        BUS_RX_ACK: begin
          if (scl_fall) begin
            bitcnt_ff <= BIT_RST;
            if (role_ff == ROLE_CTRL && shift_ff[0] == RW_READ) begin
              bus_ff   <= BUS_TX;
              drive_ff <= ~rd_byte[7];
              tx_sh_ff <= {rd_byte[6:0], 1'b1};
            end else begin
              drive_ff <= 1'b0;
              bus_ff   <= BUS_RX;
              unique case (role_ff)
                ROLE_CTRL:    role_ff <= ROLE_ADDR_HI;
                ROLE_ADDR_HI: role_ff <= ROLE_ADDR_LO;
                ROLE_ADDR_LO: role_ff <= ROLE_DATA;
                ROLE_DATA:    role_ff <= ROLE_DATA;
              endcase
            end
          end
        end
        BUS_TX: begin
          if (scl_rise) begin
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_ff == BIT_DONE) begin
              drive_ff <= 1'b0;
              bus_ff   <= BUS_TX_ACK;
            end else begin
              drive_ff <= ~tx_sh_ff[7];
              tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
            end
          end
        end
        BUS_TX_ACK: begin
          if (scl_rise) begin
            ack_ff <= ~sda_s;
          end else if (scl_fall) begin
            bitcnt_ff <= BIT_RST;
            if (ack_ff) begin
              bus_ff   <= BUS_TX;
              drive_ff <= ~rd_byte[7];
              tx_sh_ff <= {rd_byte[6:0], 1'b1};
            end else begin
              bus_ff <= BUS_WAIT;
            end
          end
        end
        default: begin
          bus_ff   <= BUS_IDLE;
          drive_ff <= 1'b0;
        end
      endcase
    end
  end

  // address pointer and write cache loading
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ahi_ff   <= 5'h00;
      ptr_ff   <= PTR_RST;
      base_ff  <= PTR_RST;
      slot_ff  <= 6'h00;
      valid_ff <= 64'h0;
    end else if (ahi_stb) begin
      ahi_ff <= rx_byte[4:0];
    end else if (alo_stb) begin
      // first byte always lands in cache page zero at the byte offset
      ptr_ff   <= {ahi_ff, rx_byte};
      base_ff  <= {ahi_ff, rx_byte[7:3], 3'h0};
      slot_ff  <= {3'h0, rx_byte[2:0]};
      valid_ff <= 64'h0;
    end else if (data_stb) begin
      valid_ff[slot_ff] <= 1'b1;
      slot_ff <= slot_ff + 6'h01;
      ptr_ff  <= {ptr_ff[12:6], ptr_ff[5:0] + 6'h01};
    end else if (tx_adv) begin
      ptr_ff <= ptr_ff + 13'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (data_stb) begin
      cache_ff[slot_ff] <= rx_byte;
    end
  end

  // an abandoned write (repeated START) must never reach the array
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      loaded_ff <= 1'b0;
    end else if (data_stb) begin
      loaded_ff <= 1'b1;
    end else if (start_c || commit_go || alo_stb) begin
      loaded_ff <= 1'b0;
    end
  end

  // commit: copy loaded bytes, then hold busy one page program time per loaded page
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cm_ff    <= CM_IDLE;
      cslot_ff <= 6'h00;
      wait_ff  <= 32'h0;
    end else begin
      unique case (cm_ff)
        CM_IDLE: begin
          if (commit_go) begin
            cm_ff    <= CM_COPY;
            cslot_ff <= 6'h00;
          end
        end
        CM_COPY: begin
          cslot_ff <= cslot_ff + 6'h01;
          if (cslot_ff == SLOT_LAST) begin
            cm_ff   <= CM_WAIT;
            wait_ff <= 32'(pages_loaded(valid_ff)) *
                       32'(PAGE_WR_CYCLES);
          end
        end
        CM_WAIT: begin
          if (wait_ff <= 32'h1) begin
            cm_ff <= CM_IDLE;
          end else begin
            wait_ff <= wait_ff - 32'h1;
          end
        end
        default: cm_ff <= CM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (cm_ff == CM_COPY && valid_ff[cslot_ff]) begin
      mem_ff[base_ff + 13'(cslot_ff)] <= cache_ff[cslot_ff];
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_tx_fall;
    (bus_ff == BUS_TX) && scl_fall && (bitcnt_ff != BIT_DONE);
  endsequence

  sequence s_drive_next;
    ##1 (drive_ff == ~$past(tx_sh_ff[7]));
  endsequence

  busy_no_ack_a: assert property (busy |-> !sda_oe_out)
    else $error("line driven while programming");
  start_seen_a: assert property (start_c && !busy |=>
      bus_ff == BUS_RX && role_ff == ROLE_CTRL && bitcnt_ff == 4'h0)
    else $error("start not taken");
  stop_idle_a: assert property (stop_c && !start_c |=>
      bus_ff == BUS_IDLE && !sda_oe_out)
    else $error("stop did not release bus");
  ack_hold_a: assert property ((bus_ff == BUS_RX_ACK) && !scl_fall |=>
      sda_oe_out)
    else $error("ack not held low");
  ctrl_match_a: assert property ((bus_ff == BUS_RX_ACK) &&
      (role_ff == ROLE_CTRL) |-> shift_ff[7:4] == TYPE_CODE &&
      shift_ff[3:1] == cs_s)
    else $error("control byte acked without match");
  tx_bit_a: assert property (s_tx_fall |-> s_drive_next)
    else $error("transmit bit not placed on fall");
  nack_rel_a: assert property ((bus_ff == BUS_TX_ACK) |-> !sda_oe_out)
    else $error("line held in master ack slot");
  ptr_low_a: assert property (data_stb |=>
      ptr_ff[12:6] == $past(ptr_ff[12:6]) &&
      ptr_ff[5:0] == $past(ptr_ff[5:0]) + 6'h01)
    else $error("write pointer step wrong");
  cache_wrap_a: assert property (data_stb && slot_ff == SLOT_LAST |=>
      slot_ff == 6'h00)
    else $error("cache slot did not wrap");
  rd_step_a: assert property (tx_adv |=>
      ptr_ff == $past(ptr_ff) + 13'h0001)
    else $error("read pointer did not advance");
  commit_go_a: assert property (commit_go |=> busy ##1 busy)
    else $error("stop did not start programming");
  abort_keep_a: assert property (start_c && loaded_ff && !busy |=>
      !loaded_ff && ptr_ff == $past(ptr_ff))
    else $error("abort lost pointer or kept data");
endmodule : sees_eeprom_slave

/* File: rtl/sees_line_sync.sv */
/*
  Two-flop synchronisers for the bus lines and select pins, plus clock
  edge and START/STOP detection on the synchronised lines.
  Assumes all inputs are asynchronous to clk_in.
*/
module sees_line_sync
  import sees_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [2:0] cs_in,
  output logic            sda_s_out,
  output logic [2:0]      cs_s_out,
  output logic            scl_rise_out,
  output logic            scl_fall_out,
  output logic            start_out,
  output logic            stop_out
);
  logic [4:0] meta_ff;
  logic [4:0] sync_ff;
  logic       scl_d_ff;
  logic       sda_d_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_ff <= 5'h1f;
      sync_ff <= 5'h1f;
    end else begin
      meta_ff <= {cs_in, sda_in, scl_in};
      sync_ff <= meta_ff;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= sync_ff[0];
      sda_d_ff <= sync_ff[1];
    end
  end

  assign sda_s_out    = sync_ff[1];
  assign cs_s_out     = sync_ff[4:2];
  assign scl_rise_out = sync_ff[0] & ~scl_d_ff;
  assign scl_fall_out = ~sync_ff[0] & scl_d_ff;
  // data moving while clock stays high is a bus condition
  assign start_out = sync_ff[0] & scl_d_ff & sda_d_ff & ~sync_ff[1];
  assign stop_out  = sync_ff[0] & scl_d_ff & ~sda_d_ff & sync_ff[1];
endmodule : sees_line_sync
